// ---- rtl/gpio_pin_edge_pkg.sv ----
package gpio_pin_edge_pkg;

  localparam int          NPIN          = 23;
  localparam int          CTRL_LSB      = 20;
  localparam int          CTRL_MSB      = 22;
  localparam int          DATA_MSB      = 19;
  localparam int          SUMMARY_BIT   = 0;
  localparam int          ADDR_W        = 8;

  localparam logic [7:0]  OFS_ENABLE    = 8'h00;
  localparam logic [7:0]  OFS_FUNCTION  = 8'h04;
  localparam logic [7:0]  OFS_DIRECTION = 8'h08;
  localparam logic [7:0]  OFS_EDGE_SEL  = 8'h0C;
  localparam logic [7:0]  OFS_PENDING   = 8'h10;
  localparam logic [7:0]  OFS_CLEAR     = 8'h14;
  localparam logic [7:0]  OFS_PORT_STAT = 8'h18;

  localparam logic [22:0] PIN_RESET     = 23'h000000;
  localparam logic [31:0] WORD_ZERO     = 32'h00000000;

  typedef struct packed {
    logic [22:0] enable;
    logic [22:0] gpio_func;
    logic [22:0] is_input;
    logic [22:0] falling;
  } pin_cfg_t;

  typedef enum {
    st_idle,
    st_ack
  } bus_state_t;

endpackage

// ---- rtl/gpio_pin_edge_interrupt.sv ----
`timescale 1ns/10ps
// Contract
// R1 - edge select bits 31-23 read zero, ignore writes
// R2 - bits 22-20: 0 rising, 1 falling, control
// R3 - bits 19-0: 0 rising, 1 falling, data
// R4 - set pending only if enabled, gpio, input
// R5 - any pending bit sets summary flag
// R6 - clear alias: one clears, zero keeps
// R7 - clearing pending leaves summary flag set
// R8 - summary flag re-sets while pending remains
// R9 - pending read-only, resets zero, upper zero
// R10 - clear alias always reads zero
// R11 - synchronise pins, set beats clear
module gpio_pin_edge_interrupt (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [22:0] i_pin,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic      [22:0] o_pin_event_pending,
  output logic             o_port_gpio_flag
);

  gpio_pin_edge_pkg::pin_cfg_t   cfg;
  gpio_pin_edge_pkg::bus_state_t state;

  logic [22:0] pin_meta;
  logic [22:0] pin_sync;
  logic [22:0] pin_prev;
  logic [22:0] rise_v;
  logic [22:0] fall_v;
  logic [22:0] armed;
  logic [22:0] set_vec;
  logic [22:0] clr_vec;
  logic [22:0] next_pending;
  logic        next_flag;
  logic        flag_clr;
  logic        wr_fire;
  logic        acc_start;
  logic        mapped;
  logic [31:0] rd_word;

  function automatic logic hit(
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    hit = (addr == ofs);
  endfunction

  assign wr_fire   = i_psel & i_penable & o_pready & i_pwrite;
  assign acc_start = i_psel & i_penable & (state == gpio_pin_edge_pkg::st_idle);

  // apb handshake, one wait state
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state    <= gpio_pin_edge_pkg::st_idle;
      o_pready <= 1'b0;
    end
    else
    begin
      case (state)
        gpio_pin_edge_pkg::st_idle:
        begin
          if (acc_start)
          begin
            state    <= gpio_pin_edge_pkg::st_ack;
            o_pready <= 1'b1;
          end
        end
        gpio_pin_edge_pkg::st_ack:
        begin
          state    <= gpio_pin_edge_pkg::st_idle;
          o_pready <= 1'b0;
        end
        default:
        begin
          state    <= gpio_pin_edge_pkg::st_idle;
          o_pready <= 1'b0;
        end
      endcase
    end
  end

  // address decode
  always_comb
  begin
    mapped  = 1'b1;
    rd_word = gpio_pin_edge_pkg::WORD_ZERO;
    if (hit(i_paddr, gpio_pin_edge_pkg::OFS_ENABLE))
      rd_word = {9'h000, cfg.enable};
    else if (hit(i_paddr, gpio_pin_edge_pkg::OFS_FUNCTION))
      rd_word = {9'h000, cfg.gpio_func};
    else if (hit(i_paddr, gpio_pin_edge_pkg::OFS_DIRECTION))
      rd_word = {9'h000, cfg.is_input};
    else if (hit(i_paddr, gpio_pin_edge_pkg::OFS_EDGE_SEL))
      rd_word = {9'h000, cfg.falling}; // R1
    else if (hit(i_paddr, gpio_pin_edge_pkg::OFS_PENDING))
      rd_word = {9'h000, o_pin_event_pending}; // R9
    else if (hit(i_paddr, gpio_pin_edge_pkg::OFS_CLEAR))
      rd_word = gpio_pin_edge_pkg::WORD_ZERO; // R10
    else if (hit(i_paddr, gpio_pin_edge_pkg::OFS_PORT_STAT))
      rd_word = {31'h00000000, o_port_gpio_flag};
    else
      mapped = 1'b0;
  end

  // read data and error, held through the ack cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_prdata  <= gpio_pin_edge_pkg::WORD_ZERO;
      o_pslverr <= 1'b0;
    end
    else if (acc_start)
    begin
      o_prdata  <= i_pwrite ? gpio_pin_edge_pkg::WORD_ZERO : rd_word;
      o_pslverr <= ~mapped;
    end
    else if (!o_pready)
    begin
      o_prdata  <= gpio_pin_edge_pkg::WORD_ZERO;
      o_pslverr <= 1'b0;
    end
  end

  // configuration registers, upper bits dropped
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cfg.enable    <= gpio_pin_edge_pkg::PIN_RESET;
      cfg.gpio_func <= gpio_pin_edge_pkg::PIN_RESET;
      cfg.is_input  <= gpio_pin_edge_pkg::PIN_RESET;
      cfg.falling   <= gpio_pin_edge_pkg::PIN_RESET;
    end
    else if (wr_fire)
    begin
      if (hit(i_paddr, gpio_pin_edge_pkg::OFS_ENABLE))
        cfg.enable <= i_pwdata[22:0];
      if (hit(i_paddr, gpio_pin_edge_pkg::OFS_FUNCTION))
        cfg.gpio_func <= i_pwdata[22:0];
      if (hit(i_paddr, gpio_pin_edge_pkg::OFS_DIRECTION))
        cfg.is_input <= i_pwdata[22:0];
      if (hit(i_paddr, gpio_pin_edge_pkg::OFS_EDGE_SEL))
        cfg.falling <= i_pwdata[22:0]; // R1
    end
  end

  // pin synchroniser and previous sample
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pin_meta <= gpio_pin_edge_pkg::PIN_RESET;
      pin_sync <= gpio_pin_edge_pkg::PIN_RESET;
      pin_prev <= gpio_pin_edge_pkg::PIN_RESET;
    end
    else
    begin
      pin_meta <= i_pin; // R11
      pin_sync <= pin_meta; // R11
      pin_prev <= pin_sync; // R11
    end
  end

  // per-pin edge select and arming
  genvar g;
  generate
    for (g = 0; g < gpio_pin_edge_pkg::NPIN; g++)
    begin : g_pin
      assign rise_v[g]  = pin_sync[g] & ~pin_prev[g];
      assign fall_v[g]  = ~pin_sync[g] & pin_prev[g];
      assign armed[g]   = cfg.enable[g] & cfg.gpio_func[g]
                          & cfg.is_input[g]; // R4
      assign set_vec[g] = armed[g]
                          & (cfg.falling[g] ? fall_v[g]
                                            : rise_v[g]); // R2 R3
    end
  endgenerate

  assign clr_vec = (wr_fire && hit(i_paddr, gpio_pin_edge_pkg::OFS_CLEAR))
                   ? i_pwdata[22:0] : gpio_pin_edge_pkg::PIN_RESET; // R6
  assign next_pending = (o_pin_event_pending & ~clr_vec)
                        | set_vec; // R6 R11

  // pending status, software only clears
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_pin_event_pending <= gpio_pin_edge_pkg::PIN_RESET; // R9
    else
      o_pin_event_pending <= next_pending; // R9
  end

  assign flag_clr = wr_fire
                    && hit(i_paddr, gpio_pin_edge_pkg::OFS_PORT_STAT)
                    && i_pwdata[gpio_pin_edge_pkg::SUMMARY_BIT];
  assign next_flag = (o_port_gpio_flag & ~flag_clr) // R7
                     | (|set_vec) // R5
                     | (|o_pin_event_pending); // R8

  // port summary flag, own w1c clear
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_port_gpio_flag <= 1'b0;
    else
      o_port_gpio_flag <= next_flag; // R5 R7 R8
  end

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  logic [22:0] pend_prev;
  logic [22:0] newly;

  // pending value one edge back
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pend_prev <= gpio_pin_edge_pkg::PIN_RESET;
    else
      pend_prev <= o_pin_event_pending;
  end

  assign newly = o_pin_event_pending & ~pend_prev;

  sequence s_edge_read;
    i_psel && i_penable && !o_pready && !i_pwrite
    && hit(i_paddr, gpio_pin_edge_pkg::OFS_EDGE_SEL);
  endsequence

  sequence s_clear_read;
    i_psel && i_penable && !o_pready && !i_pwrite
    && hit(i_paddr, gpio_pin_edge_pkg::OFS_CLEAR);
  endsequence

  sequence s_pending_write;
    wr_fire && hit(i_paddr, gpio_pin_edge_pkg::OFS_PENDING);
  endsequence

  chk_edge_upper_zero: assert property ( // R1
    s_edge_read |=> o_pready && o_prdata[31:23] == 9'h000)
    else $error("edge select upper bits not zero");

  chk_ctrl_edge_kind: assert property ( // R2
    ##1 (newly[22:20] & ~$past(cfg.falling[22:20])
         & ~$past(rise_v[22:20])) == 3'h0
    && (newly[22:20] & $past(cfg.falling[22:20])
        & ~$past(fall_v[22:20])) == 3'h0)
    else $error("control pin set on wrong edge");

  chk_data_edge_kind: assert property ( // R3
    ##1 (newly[19:0] & ~$past(cfg.falling[19:0])
         & ~$past(rise_v[19:0])) == 20'h00000
    && (newly[19:0] & $past(cfg.falling[19:0])
        & ~$past(fall_v[19:0])) == 20'h00000)
    else $error("data pin set on wrong edge");

  chk_arm_needed: assert property ( // R4
    ##1 (newly & ~$past(armed)) == 23'h000000)
    else $error("pending set on unarmed pin");

  chk_summary_set: assert property ( // R5
    (|o_pin_event_pending) |=> o_port_gpio_flag)
    else $error("summary flag missed pending bit");

  chk_clear_alias: assert property ( // R6
    (clr_vec != 23'h000000) |=>
    (o_pin_event_pending & $past(clr_vec) & ~$past(set_vec))
    == 23'h000000
    && (($past(o_pin_event_pending) & ~$past(clr_vec))
        & ~o_pin_event_pending) == 23'h000000)
    else $error("clear alias misbehaved");

  chk_flag_sticky: assert property ( // R7
    o_port_gpio_flag && !flag_clr |=> o_port_gpio_flag [*1])
    else $error("summary flag dropped without clear");

  chk_flag_reset: assert property ( // R8
    flag_clr && (|o_pin_event_pending) |=> o_port_gpio_flag)
    else $error("summary flag not re-set");

  chk_pending_ro: assert property ( // R9
    (s_pending_write and (set_vec == 23'h000000)) |=>
    o_pin_event_pending == $past(o_pin_event_pending))
    else $error("pending changed by write");

  chk_clear_reads_zero: assert property ( // R10
    s_clear_read |=> o_pready && o_prdata == 32'h00000000)
    else $error("clear alias read not zero");

  chk_set_wins: assert property ( // R11
    (set_vec != 23'h000000) |=>
    (o_pin_event_pending & $past(set_vec)) == $past(set_vec))
    else $error("set event lost");

  chk_pin_latency: assert property ( // R11
    ($rose(i_pin[3]) && armed[3] && !cfg.falling[3] && !i_psel)
    ##1 (!i_psel) |=> ##1 o_pin_event_pending[3])
    else $error("pin edge not seen in time");

endmodule // gpio_pin_edge_interrupt

// ---- dv/pin_source_model.sv ----
`timescale 1ns/10ps
module pin_source_model (
  input  wire logic        i_clk,
  input  wire logic [22:0] i_level,
  output logic      [22:0] o_pin
);
  // pins move just after a rising edge
  always_ff @(posedge i_clk)
  begin
    o_pin <= i_level;
  end
endmodule // pin_source_model

// ---- dv/gpio_pin_edge_interrupt_bench.sv ----
`timescale 1ns/10ps
module gpio_pin_edge_interrupt_bench;
  logic        i_sys_clk       = 1'b0;
  logic        i_rst_n         = 1'b0;
  logic        psel            = 1'b0;
  logic        pen             = 1'b0;
  logic        pwr             = 1'b0;
  logic [7:0]  paddr           = 8'h00;
  logic [31:0] pwdata          = 32'h00000000;
  logic [22:0] level           = 23'h000000;
  logic [22:0] pin;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        flag;
  logic [22:0] pend;
  int          num_errors      = 0;
  int          samples_checked = 0;

  always #5 i_sys_clk = ~i_sys_clk;

  pin_source_model i_src (.i_clk(i_sys_clk), .i_level(level), .o_pin(pin));

  gpio_pin_edge_interrupt i_dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pin(pin), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_pin_event_pending(pend),
    .o_port_gpio_flag(flag)
  );

  task automatic stop_test;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one transfer; entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_sys_clk);
    pen <= 1'b1;
    do
    begin
      @(posedge i_sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      check(32'h00000000, 32'hFFFFFFFF);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h00000000, r, e);
    check(r, exp);
  endtask

  task automatic pins(input logic [22:0] v);
    level <= v;
    repeat (6) @(posedge i_sys_clk);
  endtask

  task automatic t_reset;
    rd_chk(gpio_pin_edge_pkg::OFS_EDGE_SEL, 32'h00000000);
    rd_chk(gpio_pin_edge_pkg::OFS_PENDING, 32'h00000000);
    rd_chk(gpio_pin_edge_pkg::OFS_PORT_STAT, 32'h00000000);
  endtask

  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    wr(gpio_pin_edge_pkg::OFS_EDGE_SEL, 32'hFFFFFFFF);
    rd_chk(gpio_pin_edge_pkg::OFS_EDGE_SEL, 32'h007FFFFF);
    wr(gpio_pin_edge_pkg::OFS_PENDING, 32'hFFFFFFFF);
    rd_chk(gpio_pin_edge_pkg::OFS_PENDING, 32'h00000000);
    wr(gpio_pin_edge_pkg::OFS_CLEAR, 32'hFFFFFFFF);
    rd_chk(gpio_pin_edge_pkg::OFS_CLEAR, 32'h00000000);
    apb(1'b0, 8'h1C, 32'h00000000, r, e);
    check({31'h00000000, e}, 32'h00000001);
    wr(gpio_pin_edge_pkg::OFS_EDGE_SEL, 32'h00000000);
  endtask

  // pin 0 not gpio, pin 1 output, pin 2 not enabled
  task automatic t_rise;
    wr(gpio_pin_edge_pkg::OFS_ENABLE, 32'h007FFFFB);
    wr(gpio_pin_edge_pkg::OFS_FUNCTION, 32'h007FFFFE);
    wr(gpio_pin_edge_pkg::OFS_DIRECTION, 32'h007FFFFD);
    pins(23'h7FFFFF);
    check({9'h000, pend}, 32'h007FFFF8);
    check({31'h00000000, flag}, 32'h00000001);
    rd_chk(gpio_pin_edge_pkg::OFS_PORT_STAT, 32'h00000001);
  endtask

  task automatic t_clear;
    wr(gpio_pin_edge_pkg::OFS_CLEAR, 32'h007FFFF0);
    check({9'h000, pend}, 32'h00000008);
    wr(gpio_pin_edge_pkg::OFS_PORT_STAT, 32'h00000001);
    rd_chk(gpio_pin_edge_pkg::OFS_PORT_STAT, 32'h00000001);
    check({31'h00000000, flag}, 32'h00000001);
    wr(gpio_pin_edge_pkg::OFS_CLEAR, 32'h00000008);
    check({9'h000, pend}, 32'h00000000);
    rd_chk(gpio_pin_edge_pkg::OFS_PORT_STAT, 32'h00000001);
    wr(gpio_pin_edge_pkg::OFS_PORT_STAT, 32'h00000001);
    rd_chk(gpio_pin_edge_pkg::OFS_PORT_STAT, 32'h00000000);
    check({31'h00000000, flag}, 32'h00000000);
    pins(23'h000000);
    check({9'h000, pend}, 32'h00000000);
  endtask

  // control lines falling, data lines rising
  task automatic t_mixed;
    wr(gpio_pin_edge_pkg::OFS_EDGE_SEL, 32'h00700000);
    pins(23'h7FFFFF);
    check({9'h000, pend}, 32'h000FFFF8);
    wr(gpio_pin_edge_pkg::OFS_CLEAR, 32'h007FFFFF);
    pins(23'h000000);
    check({9'h000, pend}, 32'h00700000);
    rd_chk(gpio_pin_edge_pkg::OFS_PENDING, 32'h00700000);
  endtask

  // control lines rising, data lines falling
  task automatic t_data_fall;
    wr(gpio_pin_edge_pkg::OFS_CLEAR, 32'h007FFFFF);
    wr(gpio_pin_edge_pkg::OFS_EDGE_SEL, 32'h000FFFFF);
    pins(23'h7FFFFF);
    check({9'h000, pend}, 32'h00700000);
    wr(gpio_pin_edge_pkg::OFS_CLEAR, 32'h007FFFFF);
    pins(23'h000000);
    check({9'h000, pend}, 32'h000FFFF8);
  endtask

  initial
  begin
    repeat (10) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
    t_reset();
    t_regs();
    t_rise();
    t_clear();
    t_mixed();
    t_data_fall();
    stop_test();
  end

  initial
  begin
    #100us;
    num_errors++;
    stop_test();
  end
endmodule // gpio_pin_edge_interrupt_bench
